/* verilog/pec_pkg.sv */
// Constants, types and register map of the pattern error-rate checker.
package pec_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned PEC_SYS_CLK_HZ   = 25_000_000;
    localparam int unsigned PEC_CLK_PER_NS   = 1_000_000_000 / PEC_SYS_CLK_HZ;
    localparam int unsigned PEC_SAMPLE_HZ    = 320_000;
    localparam int unsigned PEC_SAMPLE_DIV   = PEC_SYS_CLK_HZ / PEC_SAMPLE_HZ;
    localparam logic [6:0]  PEC_SAMPLE_LAST  = 7'(PEC_SAMPLE_DIV - 1);
    localparam logic [3:0]  PEC_MID_COUNT    = 4'h8;
    localparam logic [3:0]  PEC_GEN_LAST     = 4'hF;
    localparam int unsigned PEC_LOSS_NS      = 200_000;
    localparam int unsigned PEC_LOSS_CYCLES  = (PEC_LOSS_NS + PEC_CLK_PER_NS - 1) / PEC_CLK_PER_NS;

    // ----------------------------------------------------------------
    // Pattern, sync and integrator
    // ----------------------------------------------------------------
    localparam logic [10:0] PEC_LFSR_SEED    = 11'h7FF;
    localparam logic [4:0]  PEC_SYNC_BITS    = 5'h10;
    localparam logic [13:0] PEC_WIN_LAST     = 14'h3FFF;
    localparam logic [7:0]  PEC_ERR_LIMIT    = 8'hA4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  PEC_OFF_CTRL     = 8'h00;
    localparam logic [7:0]  PEC_OFF_STATUS   = 8'h04;
    localparam logic [7:0]  PEC_OFF_INT_STAT = 8'h08;
    localparam logic [7:0]  PEC_OFF_INT_MASK = 8'h0C;
    localparam logic [7:0]  PEC_OFF_ERR_CNT  = 8'h10;
    localparam logic [4:0]  PEC_MASK_RST     = 5'h00;

    // Rate selection held in the control register bits [1:0].
    typedef enum logic [1:0] {
        PEC_MODE_50K,
        PEC_MODE_20K,
        PEC_MODE_EXT,
        PEC_MODE_SELF
    } pec_mode_t;

    // Front-panel lamps; also the layout of the status register.
    typedef struct packed {
        logic self_fail;
        logic high_density;
        logic clk_lost;
        logic bit_error;
        logic sync;
    } pec_lamps_t;

    // Sticky event bits; also the layout of interrupt status and mask registers.
    typedef struct packed {
        logic high_density;
        logic clk_lost;
        logic sync_lost;
        logic sync_gained;
        logic mismatch;
    } pec_events_t;

endpackage : pec_pkg

/* verilog/pec_checker.sv */
// Receive-side pattern error-rate checker with self-test loopback and APB registers.
`timescale 1ns/10ps
module pec_checker #(
    parameter int unsigned LOSS_CYCLES = pec_pkg::PEC_LOSS_CYCLES
) (
    // Clock, reset, enable
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Link under test
    input  wire logic               rx_pattern_input,
    input  wire logic               rx_clock_input,
    output logic                    tx_pattern_out,
    // Panel and alarms
    output pec_pkg::pec_lamps_t     lamps,
    output logic                    alarm_fault,
    output logic                    irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic                rx_data_s1_q, rx_data_s2_q;
    logic                rx_clk_s1_q, rx_clk_s2_q, rx_clk_s3_q;
    logic [6:0]          div_q;
    logic                tick;
    logic                samp_q;
    logic [3:0]          phase_q;
    logic                mid_q;
    logic [3:0]          gen_div_q;
    logic                gen_tick;
    logic [10:0]         gen_q;
    logic                din;
    logic                rec_mode;
    logic                clk_rise;
    logic                bit_tick;
    logic                bit_data;
    logic [10:0]         chk_q;
    logic                expected;
    logic                mism;
    logic [4:0]          load_cnt_q;
    logic                in_sync_q;
    logic                sync_gain;
    logic [13:0]         win_cnt_q;
    logic [7:0]          err_cnt_q;
    logic                hi_q;
    logic                hi_set;
    logic [15:0]         loss_cnt_q;
    logic                clk_lost_q;
    logic                bit_err_q;
    pec_pkg::pec_mode_t  mode_q;
    pec_pkg::pec_events_t int_stat_q, int_mask_q, ev;
    pec_pkg::pec_lamps_t lamps_q;
    logic                ack_q;
    logic [31:0]         prdata_q;
    logic [31:0]         rd_data;
    logic                hit;
    logic                done;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Both link pins are asynchronous; the third clock stage serves edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_s1_q <= 1'b0;
            rx_data_s2_q <= 1'b0;
            rx_clk_s1_q  <= 1'b0;
            rx_clk_s2_q  <= 1'b0;
            rx_clk_s3_q  <= 1'b0;
        end else if (pce) begin
            rx_data_s1_q <= rx_pattern_input;
            rx_data_s2_q <= rx_data_s1_q;
            rx_clk_s1_q  <= rx_clock_input;
            rx_clk_s2_q  <= rx_clk_s1_q;
            rx_clk_s3_q  <= rx_clk_s2_q;
        end
    end

    assign clk_rise = rx_clk_s2_q & ~rx_clk_s3_q;

    // ----------------------------------------------------------------
    // Sampling clock
    // ----------------------------------------------------------------
    // The divide ratio is whole cycles, so the sampling rate sits slightly above nominal.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 7'h00;
        end else if (pce) begin
            div_q <= (div_q == pec_pkg::PEC_SAMPLE_LAST) ? 7'h00 : div_q + 7'h01;
        end
    end

    assign tick = pce & (div_q == pec_pkg::PEC_SAMPLE_LAST);

    // ----------------------------------------------------------------
    // Self-test pattern generator
    // ----------------------------------------------------------------
    // The generator steps every sixteenth sample, giving the 20 kb/s rate.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_div_q <= 4'h0;
        end else if (tick) begin
            gen_div_q <= gen_div_q + 4'h1;
        end
    end

    assign gen_tick = tick & (gen_div_q == pec_pkg::PEC_GEN_LAST);

    // An all-zero state would lock the register, so a one is forced in.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q <= pec_pkg::PEC_LFSR_SEED;
        end else if (gen_tick) begin
            gen_q <= {gen_q[9:0], (gen_q[10] ^ gen_q[8]) | (gen_q == 11'h000)};
        end
    end

    assign tx_pattern_out = gen_q[10];
    assign din            = (mode_q == pec_pkg::PEC_MODE_SELF) ? gen_q[10] : rx_data_s2_q;
    assign rec_mode       = (mode_q == pec_pkg::PEC_MODE_20K) |
                            (mode_q == pec_pkg::PEC_MODE_SELF);

    // ----------------------------------------------------------------
    // Clock recovery receiver
    // ----------------------------------------------------------------
    // Without edges the counter wraps at sixteen and keeps producing mid-bit pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q  <= 1'b0;
            phase_q <= 4'h0;
            mid_q   <= 1'b0;
        end else if (pce) begin
            mid_q <= 1'b0;
            if (tick) begin
                samp_q <= din;
                if (din != samp_q) begin
                    phase_q <= 4'h0;
                end else begin
                    phase_q <= phase_q + 4'h1;
                    mid_q   <= rec_mode & (phase_q + 4'h1 == pec_pkg::PEC_MID_COUNT);
                end
            end
        end
    end

    a_mid_at_eight: assert property (@(posedge pclk) disable iff (!presetn)
        pce && mid_q |-> phase_q == pec_pkg::PEC_MID_COUNT && rec_mode)
        else $error("mid-bit pulse away from count eight");
    a_edge_restart: assert property (@(posedge pclk) disable iff (!presetn)
        tick && din != samp_q |=> phase_q == 4'h0 && !mid_q)
        else $error("data edge did not restart the count");
    a_count_recirc: assert property (@(posedge pclk) disable iff (!presetn)
        tick && din == samp_q && phase_q == 4'hF |=> phase_q == 4'h0)
        else $error("recovery count did not recirculate");

    // ----------------------------------------------------------------
    // Checker clock selection
    // ----------------------------------------------------------------
    assign bit_tick = pce & (rec_mode ? mid_q : clk_rise);
    assign bit_data = rec_mode ? samp_q : rx_data_s2_q;

    a_clock_select: assert property (@(posedge pclk) disable iff (!presetn)
        bit_tick |-> (rec_mode && mid_q) || (!rec_mode && clk_rise))
        else $error("checker clocked from the wrong source");

    // ----------------------------------------------------------------
    // Word detector
    // ----------------------------------------------------------------
    assign expected = chk_q[10] ^ chk_q[8];
    assign mism     = bit_tick & (bit_data ^ expected);
    assign sync_gain = bit_tick & ~in_sync_q & (load_cnt_q == pec_pkg::PEC_SYNC_BITS - 5'h01);

    // Feed-forward while hunting, then the register runs on its own feedback.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_q      <= pec_pkg::PEC_LFSR_SEED;
            load_cnt_q <= 5'h00;
            in_sync_q  <= 1'b0;
        end else if (bit_tick) begin
            if (in_sync_q) begin
                chk_q <= {chk_q[9:0], expected};
            end else begin
                chk_q      <= {chk_q[9:0], bit_data};
                load_cnt_q <= load_cnt_q + 5'h01;
                if (sync_gain) begin
                    in_sync_q <= 1'b1;
                end
            end
            // A density alarm restarts the hunt even if it meets the sixteenth bit.
            if (hi_set) begin
                in_sync_q  <= 1'b0;
                load_cnt_q <= 5'h00;
            end
        end
    end

    a_sync_within: assert property (@(posedge pclk) disable iff (!presetn)
        sync_gain && !hi_set |=> in_sync_q && load_cnt_q == pec_pkg::PEC_SYNC_BITS)
        else $error("sync not reached after sixteen bits");
    a_feedback_run: assert property (@(posedge pclk) disable iff (!presetn)
        bit_tick && in_sync_q |=> chk_q[0] == $past(expected))
        else $error("synchronised register not on self-feedback");

    // ----------------------------------------------------------------
    // Error density integrator
    // ----------------------------------------------------------------
    // The error that would make the count pass the limit sets the latch instead.
    assign hi_set = mism & ~hi_q & (err_cnt_q == pec_pkg::PEC_ERR_LIMIT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_q <= 14'h0000;
            err_cnt_q <= 8'h00;
        end else if (bit_tick) begin
            if (win_cnt_q == pec_pkg::PEC_WIN_LAST) begin
                win_cnt_q <= 14'h0000;
                err_cnt_q <= 8'h00;
            end else begin
                win_cnt_q <= win_cnt_q + 14'h0001;
                if (mism && !hi_q && !hi_set) begin
                    err_cnt_q <= err_cnt_q + 8'h01;
                end
            end
        end
    end

    // Latch holds until the checker resynchronises; a new set wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 1'b0;
        end else if (pce) begin
            if (hi_set) begin
                hi_q <= 1'b1;
            end else if (sync_gain) begin
                hi_q <= 1'b0;
            end
        end
    end

    a_window_clear: assert property (@(posedge pclk) disable iff (!presetn)
        bit_tick && win_cnt_q == pec_pkg::PEC_WIN_LAST |=> win_cnt_q == 14'h0000
        && err_cnt_q == 8'h00)
        else $error("window counters not cleared");
    a_density_latch: assert property (@(posedge pclk) disable iff (!presetn)
        hi_set |=> hi_q && !in_sync_q)
        else $error("error density latch not set");
    a_count_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
        hi_q && win_cnt_q != pec_pkg::PEC_WIN_LAST |=> $stable(err_cnt_q))
        else $error("errors counted while latched");

    // ----------------------------------------------------------------
    // Receive clock loss
    // ----------------------------------------------------------------
    // Timeout spans several bit periods so a slow but live clock never trips it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_cnt_q <= 16'h0000;
            clk_lost_q <= 1'b0;
        end else if (pce) begin
            if (bit_tick) begin
                loss_cnt_q <= 16'h0000;
                clk_lost_q <= 1'b0;
            end else if (loss_cnt_q == 16'(LOSS_CYCLES - 1)) begin
                clk_lost_q <= 1'b1;
            end else begin
                loss_cnt_q <= loss_cnt_q + 16'h0001;
            end
        end
    end

    a_clock_loss: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !bit_tick && loss_cnt_q == 16'(LOSS_CYCLES - 1) |=> ##1 lamps.clk_lost)
        else $error("clock loss lamp not raised");

    // ----------------------------------------------------------------
    // Lamps and alarm
    // ----------------------------------------------------------------
    // The bit error lamp holds each compare result until the next received bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_err_q <= 1'b0;
            lamps_q   <= '0;
        end else if (pce) begin
            if (bit_tick) begin
                bit_err_q <= mism;
            end
            lamps_q.sync         <= in_sync_q;
            lamps_q.bit_error    <= bit_err_q;
            lamps_q.clk_lost     <= clk_lost_q;
            lamps_q.high_density <= hi_q;
            lamps_q.self_fail    <= hi_q & (mode_q == pec_pkg::PEC_MODE_SELF);
        end
    end

    assign lamps       = lamps_q;
    assign alarm_fault = lamps_q.self_fail;

    a_sync_lamp: assert property (@(posedge pclk) disable iff (!presetn)
        pce |=> lamps.sync == $past(in_sync_q))
        else $error("sync lamp disagrees with sync state");
    a_self_fail: assert property (@(posedge pclk) disable iff (!presetn)
        pce && hi_q && mode_q == pec_pkg::PEC_MODE_SELF |=> alarm_fault
        && lamps.high_density)
        else $error("self-test failure not signalled");

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    always_comb begin
        ev              = '0;
        ev.mismatch     = mism;
        ev.sync_gained  = sync_gain;
        ev.sync_lost    = bit_tick & in_sync_q & hi_set;
        ev.clk_lost     = pce & ~clk_lost_q & ~bit_tick & (loss_cnt_q == 16'(LOSS_CYCLES - 1));
        ev.high_density = hi_set;
    end

    // A read clears the sticky bits, but an event in that same cycle stays set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= '0;
        end else if (pce) begin
            if (done && !pwrite && paddr == pec_pkg::PEC_OFF_INT_STAT) begin
                int_stat_q <= ev;
            end else begin
                int_stat_q <= int_stat_q | ev;
            end
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    a_mismatch_event: assert property (@(posedge pclk) disable iff (!presetn)
        mism |=> int_stat_q.mismatch)
        else $error("mismatch event lost");

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state lets read data come from a flip-flop.
    always_comb begin
        rd_data = 32'h0000_0000;
        hit     = 1'b1;
        case (paddr)
            pec_pkg::PEC_OFF_CTRL:     rd_data = {30'h0000_0000, mode_q};
            pec_pkg::PEC_OFF_STATUS:   rd_data = {27'h000_0000, lamps_q};
            pec_pkg::PEC_OFF_INT_STAT: rd_data = {27'h000_0000, int_stat_q};
            pec_pkg::PEC_OFF_INT_MASK: rd_data = {27'h000_0000, int_mask_q};
            pec_pkg::PEC_OFF_ERR_CNT:  rd_data = {24'h00_0000, err_cnt_q};
            default:                   hit     = 1'b0;
        endcase
    end

    assign pready  = psel & penable & ack_q;
    assign done    = pce & pready;
    assign pslverr = pready & ~hit;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (pce) begin
            ack_q <= psel & penable & ~ack_q;
            if (psel && penable && !ack_q && !pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end

    // Writable registers take effect only at the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= pec_pkg::PEC_MODE_50K;
            int_mask_q <= pec_pkg::PEC_MASK_RST;
        end else if (done && pwrite) begin
            if (paddr == pec_pkg::PEC_OFF_CTRL) begin
                mode_q <= pec_pkg::pec_mode_t'(pwdata[1:0]);
            end
            if (paddr == pec_pkg::PEC_OFF_INT_MASK) begin
                int_mask_q <= pwdata[4:0];
            end
        end
    end

endmodule : pec_checker

/* verif/pec_link_model.sv */
// Far-side model: a data channel returning the test pattern, with clock and error injection.
`timescale 1ns/10ps
module pec_link_model (
    // Control from the bench
    input  wire logic run,
    input  wire logic slow,
    // Link toward the checker
    output logic      rx_clock_input,
    output logic      rx_pattern_input
);
    logic [10:0] lfsr_q;
    int          err_left;

    // Invert the next n bits that go out.
    task inject(input int n);
        err_left = n;
    endtask : inject

    // -----------------------------------------------------------------
    // Pattern source
    // -----------------------------------------------------------------
    // Data changes while the clock is low; a stopped link holds its clock low
    // and toggles the data so that no stale level can be mistaken for a bit.
    initial begin
        rx_clock_input   = 1'b0;
        rx_pattern_input = 1'b1;
        lfsr_q           = 11'h7FF;
        err_left         = 0;
        #7;
        forever begin
            if (!run) begin
                rx_pattern_input = ~rx_pattern_input;
                #160;
            end else begin
                rx_pattern_input = lfsr_q[10] ^ (err_left > 0);
                if (err_left > 0) err_left--;
                lfsr_q = {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
                if (slow) begin
                    #50000;
                end else begin
                    #160 rx_clock_input = 1'b1;
                    #160 rx_clock_input = 1'b0;
                end
            end
        end
    end
endmodule : pec_link_model

/* verif/pec_checker_bench.sv */
// Self-checking bench for the pattern error-rate checker.
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module pec_checker_bench;
    localparam int EXT_BIT = 8;
    localparam int SLOW_BIT = 1250;
    localparam int LOSS = 1500;
    logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        rx_pattern_input, rx_clock_input, tx_pattern_out, alarm_fault, irq;
    logic        link_run, link_slow, se;
    pec_pkg::pec_lamps_t lamps;
    int          err_count, comparisons, cyc;

    pec_checker #(.LOSS_CYCLES(LOSS)) i_dut (
        .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pattern_input(rx_pattern_input),
        .rx_clock_input(rx_clock_input), .tx_pattern_out(tx_pattern_out), .lamps(lamps),
        .alarm_fault(alarm_fault), .irq(irq));
    pec_link_model i_link (.run(link_run), .slow(link_slow),
        .rx_clock_input(rx_clock_input), .rx_pattern_input(rx_pattern_input));

    // -----------------------------------------------------------------
    // Clock, watchdog and verdict
    // -----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // A hang is cut short well above the expected run of about 64k cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            summarize();
        end
    end
    task summarize;
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    // One APB transfer; the request is held until pready is seen high or 20 more cycles pass.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        `CHK(pready, 1'b1)
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task bits(input int n, input int per);
        repeat (n * per) @(posedge pclk);
        @(negedge pclk);
    endtask : bits
    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
    endtask : do_reset

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task t_reset;
        `CHK(lamps, 5'h00)
        `CHK(irq, 1'b0)
        `CHK(tx_pattern_out, 1'b1)
        apb(1'b0, pec_pkg::PEC_OFF_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, pec_pkg::PEC_OFF_INT_MASK, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({se, rd}, {1'b1, 32'h0})
    endtask : t_reset
    task t_sync_ext;
        apb(1'b1, pec_pkg::PEC_OFF_CTRL, {30'h0, pec_pkg::PEC_MODE_EXT});
        link_run <= 1'b1;
        bits(20, EXT_BIT);
        `CHK(lamps.sync, 1'b1)
        `CHK(lamps.bit_error, 1'b0)
        `CHK(irq, 1'b0)
        apb(1'b1, pec_pkg::PEC_OFF_INT_MASK, 32'h1F);
        bits(1, 2);
        `CHK(irq, 1'b1)
        apb(1'b0, pec_pkg::PEC_OFF_INT_STAT, 32'h0);
        `CHK(rd[1], 1'b1)
        bits(1, 2);
        `CHK(irq, 1'b0)
    endtask : t_sync_ext
    task t_density;
        apb(1'b0, pec_pkg::PEC_OFF_ERR_CNT, 32'h0);
        i_link.inject(164 - int'(rd[7:0]));
        bits(170, EXT_BIT);
        `CHK(lamps.high_density, 1'b0)
        `CHK(irq, 1'b1)
        apb(1'b0, pec_pkg::PEC_OFF_ERR_CNT, 32'h0);
        `CHK(rd, 32'hA4)
        apb(1'b0, pec_pkg::PEC_OFF_INT_STAT, 32'h0);
        `CHK(rd[0], 1'b1)
        i_link.inject(1);
        bits(4, EXT_BIT);
        `CHK({lamps.high_density, lamps.sync}, 2'b10)
        apb(1'b0, pec_pkg::PEC_OFF_INT_STAT, 32'h0);
        `CHK({rd[4], rd[2]}, 2'b11)
        bits(24, EXT_BIT);
        `CHK({lamps.high_density, lamps.sync}, 2'b01)
    endtask : t_density
    task t_loss;
        link_run <= 1'b0;
        bits(1000, 1);
        `CHK(lamps.clk_lost, 1'b0)
        bits(700, 1);
        `CHK(lamps.clk_lost, 1'b1)
        apb(1'b0, pec_pkg::PEC_OFF_INT_STAT, 32'h0);
        `CHK(rd[3], 1'b1)
        link_run <= 1'b1;
        bits(8, EXT_BIT);
        `CHK(lamps.clk_lost, 1'b0)
    endtask : t_loss
    // The link clock stands still here, so sync proves the mid-bit recovery.
    task t_rate20;
        link_slow <= 1'b1;
        do_reset();
        apb(1'b1, pec_pkg::PEC_OFF_CTRL, {30'h0, pec_pkg::PEC_MODE_20K});
        bits(24, SLOW_BIT);
        `CHK(lamps.sync, 1'b1)
        `CHK({lamps.bit_error, lamps.clk_lost}, 2'b00)
    endtask : t_rate20
    task t_self;
        link_run <= 1'b0;
        do_reset();
        apb(1'b1, pec_pkg::PEC_OFF_CTRL, {30'h0, pec_pkg::PEC_MODE_SELF});
        bits(24, SLOW_BIT);
        `CHK(lamps.sync, 1'b1)
        `CHK({lamps.self_fail, lamps.high_density, alarm_fault}, 3'b000)
    endtask : t_self

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, link_run, link_slow} = 6'h00;
        pce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        t_sync_ext();
        t_density();
        t_loss();
        t_rate20();
        t_self();
        summarize();
    end
endmodule : pec_checker_bench
